// ===== gio_pkg.sv
// package: register map, reset values and field layout of the i/o ports block
`default_nettype none
package gio_pkg;
  // ---------------------------------------------------------------
  // register addresses in data memory
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_A = 8'h12;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h13;
  localparam logic [7:0] ADDR_PORT_B = 8'h14;
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h15;
  localparam logic [7:0] ADDR_PORT_D = 8'h18;
  localparam logic [7:0] ADDR_PORT_D_DIR = 8'h19;
  localparam logic [7:0] ADDR_PWM_DUTY = 8'h1a;
  // ---------------------------------------------------------------
  // reset values and line counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_LATCH = 8'hff;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam int PORT_A_LINES = 8;
  localparam int PORT_B_LINES = 5;
  localparam int PORT_D_LINES = 1;
  // ---------------------------------------------------------------
  // pin positions and duty fields
  // ---------------------------------------------------------------
  localparam int PA_LINE_DIVIDER = 3;
  localparam int PA_LINE_TIMER_CLK = 4;
  localparam int PA_LINE_EXT_INT = 5;
  localparam int PD_LINE_PWM = 0;
  localparam int DUTY_COARSE_LSB = 2;
  localparam int DUTY_FINE_W = 2;
  localparam int MOD_CYCLE_CLKS = 64;
  // ---------------------------------------------------------------
  // read-modify-write operations
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    GIO_BOP_SET = 2'h0,
    GIO_BOP_CLR = 2'h1,
    GIO_BOP_CPL = 2'h2,
    GIO_BOP_CPLA = 2'h3
  } gio_bop_e;
endpackage
`default_nettype wire

// ===== gio_port_if.sv
// interface: signals between the register decoder and one port
`timescale 1ns/1ns
`default_nettype none
interface gio_port_if;
  logic wr_latch;
  logic wr_dir;
  logic [7:0] wdata;
  logic [7:0] pin_in;
  logic [7:0] latch_q;
  logic [7:0] dir_q;
  logic [7:0] rd_val;
  modport port (input wr_latch, input wr_dir, input wdata, input pin_in,
    output latch_q, output dir_q, output rd_val);
  modport ctrl (output wr_latch, output wr_dir, output wdata, output pin_in,
    input latch_q, input dir_q, input rd_val);
endinterface
`default_nettype wire

// ===== gio_port.sv
// one i/o port: output latch, direction register and read path
`timescale 1ns/1ns
`default_nettype none
module gio_port #(
  parameter int LINES = 8
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // decoder side
  gio_port_if.port bus
);
  import gio_pkg::*;
  localparam logic [7:0] LINE_MASK = 8'((9'h001 << LINES) - 9'h001);

  // ---------------------------------------------------------------
  // latch and direction
  // ---------------------------------------------------------------
  // missing lines hold zero so they read back as zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bus.latch_q <= RST_LATCH & LINE_MASK;
    end else if (bus.wr_latch) begin
      bus.latch_q <= bus.wdata & LINE_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      bus.dir_q <= RST_DIR & LINE_MASK;
    end else if (bus.wr_dir) begin
      bus.dir_q <= bus.wdata & LINE_MASK;
    end
  end

  // ---------------------------------------------------------------
  // read path: pad for inputs, latch for outputs, no input latch
  // ---------------------------------------------------------------
  assign bus.rd_val = ((bus.dir_q & bus.pin_in) | (~bus.dir_q & bus.latch_q))
    & LINE_MASK;
endmodule
`default_nettype wire

// ===== gio_pwm.sv
// shared prescaler counter and (6+2) bit pwm waveform
`timescale 1ns/1ns
`default_nettype none
module gio_pwm (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // control
  input wire logic [2:0] i_prescale_select,
  input wire logic [7:0] i_duty,
  // results
  output logic o_timer_tick,
  output logic o_wave
);
  import gio_pkg::*;
  logic [7:0] cnt_q;
  logic [7:0] tick_mask;
  logic [5:0] coarse;
  logic [1:0] fine;
  logic [1:0] mod_idx;
  logic [6:0] high_clks;
  logic wave_q;

  // ---------------------------------------------------------------
  // free running counter, prescaler and pwm share it
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // one tick every 2^select system clocks
  assign tick_mask = 8'((9'h001 << i_prescale_select) - 9'h001);
  assign o_timer_tick = (cnt_q & tick_mask) == tick_mask;

  // ---------------------------------------------------------------
  // waveform: low 6 bits walk the modulation cycle
  // ---------------------------------------------------------------
  assign coarse = i_duty[7:DUTY_COARSE_LSB];
  assign fine = i_duty[DUTY_FINE_W-1:0];
  assign mod_idx = cnt_q[7:6];
  assign high_clks = {1'b0, coarse} + {6'h00, mod_idx < fine};

  // registered so the pin never glitches on compare edges
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      wave_q <= 1'b0;
    end else begin
      wave_q <= {1'b0, cnt_q[5:0]} < high_clks;
    end
  end
  assign o_wave = wave_q;
endmodule
`default_nettype wire

// ===== gio_top.sv
// top: three i/o ports with divider and pwm alternate outputs
`timescale 1ns/1ns
`default_nettype none
module gio_top #(
  parameter bit PFD_OPTION = 1'b1,
  parameter bit PWM_OPTION = 1'b1,
  parameter bit PULLUP_A = 1'b1,
  parameter bit PULLUP_B = 1'b1,
  parameter bit PULLUP_D = 1'b1
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_srst,
  // cpu data memory access
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  input wire logic i_bop,
  input wire gio_pkg::gio_bop_e i_bop_code,
  input wire logic [2:0] i_bop_bit,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  // timer side
  input wire logic [2:0] i_prescale_select,
  input wire logic i_timer_on,
  input wire logic i_timer_ovf,
  output logic o_timer_tick,
  output logic o_timer_clk_pin,
  output logic o_ext_int_n,
  output logic o_wake,
  // port a pins
  input wire logic [7:0] i_port_a,
  output logic [7:0] o_port_a,
  output logic [7:0] o_port_a_oe,
  output logic o_port_a_pullup,
  // port b pins
  input wire logic [4:0] i_port_b,
  output logic [4:0] o_port_b,
  output logic [4:0] o_port_b_oe,
  output logic o_port_b_pullup,
  // port d pins
  input wire logic i_port_d,
  output logic o_port_d,
  output logic o_port_d_oe,
  output logic o_port_d_pullup
);
  import gio_pkg::*;

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  gio_port_if pa_if();
  gio_port_if pb_if();
  gio_port_if pd_if();
  logic [7:0] duty_q;
  logic [7:0] rd_mux;
  logic [7:0] bop_val;
  logic [7:0] bit_sel;
  logic [7:0] wr_val;
  logic wr_any;
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic pfd_q;
  logic wave;
  logic [7:0] pa_prev_q;
  logic wake_q;

  // ---------------------------------------------------------------
  // read mux over the register map
  // ---------------------------------------------------------------
  always_comb begin
    unique case (i_addr)
      ADDR_PORT_A: rd_mux = pa_if.rd_val;
      ADDR_PORT_A_DIR: rd_mux = pa_if.dir_q;
      ADDR_PORT_B: rd_mux = pb_if.rd_val;
      ADDR_PORT_B_DIR: rd_mux = pb_if.dir_q;
      ADDR_PORT_D: rd_mux = pd_if.rd_val;
      ADDR_PORT_D_DIR: rd_mux = pd_if.dir_q;
      ADDR_PWM_DUTY: rd_mux = duty_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // read-modify-write: whole port state is read, then one bit set or cleared, or all bits complemented
  // ---------------------------------------------------------------
  assign bit_sel = 8'h01 << i_bop_bit;
  always_comb begin
    unique case (i_bop_code)
      GIO_BOP_SET: bop_val = rd_mux | bit_sel;
      GIO_BOP_CLR: bop_val = rd_mux & ~bit_sel;
      GIO_BOP_CPL: bop_val = ~rd_mux;
      GIO_BOP_CPLA: bop_val = ~rd_mux;
    endcase
  end

  // a plain write wins over a bit op in the same cycle
  assign wr_val = i_wr ? i_wdata : bop_val;
  assign wr_any = i_wr | (i_bop & (i_bop_code != GIO_BOP_CPLA));

  // ---------------------------------------------------------------
  // ports
  // ---------------------------------------------------------------
  assign pa_if.wr_latch = wr_any & (i_addr == ADDR_PORT_A);
  assign pa_if.wr_dir = wr_any & (i_addr == ADDR_PORT_A_DIR);
  assign pa_if.wdata = wr_val;
  assign pa_if.pin_in = i_port_a;
  assign pb_if.wr_latch = wr_any & (i_addr == ADDR_PORT_B);
  assign pb_if.wr_dir = wr_any & (i_addr == ADDR_PORT_B_DIR);
  assign pb_if.wdata = wr_val;
  assign pb_if.pin_in = {3'h0, i_port_b};
  assign pd_if.wr_latch = wr_any & (i_addr == ADDR_PORT_D);
  assign pd_if.wr_dir = wr_any & (i_addr == ADDR_PORT_D_DIR);
  assign pd_if.wdata = wr_val;
  assign pd_if.pin_in = {7'h00, i_port_d};

  gio_port #(.LINES(PORT_A_LINES)) u_port_a (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .bus(pa_if)
  );
  gio_port #(.LINES(PORT_B_LINES)) u_port_b (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .bus(pb_if)
  );
  gio_port #(.LINES(PORT_D_LINES)) u_port_d (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .bus(pd_if)
  );

  // ---------------------------------------------------------------
  // duty register
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      duty_q <= RST_DUTY;
    end else if (wr_any && i_addr == ADDR_PWM_DUTY) begin
      duty_q <= wr_val;
    end
  end

  // ---------------------------------------------------------------
  // read answer, one cycle after the request
  // ---------------------------------------------------------------
  // pins are caught on the same edge the read is taken
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= i_rd | (i_bop & (i_bop_code == GIO_BOP_CPLA));
      if (i_bop && i_bop_code == GIO_BOP_CPLA) begin
        rdata_q <= bop_val;
      end else if (i_rd) begin
        rdata_q <= rd_mux;
      end
    end
  end
  assign o_rdata = rdata_q;
  assign o_rvalid = rvalid_q;

  // ---------------------------------------------------------------
  // prescaler and pwm
  // ---------------------------------------------------------------
  gio_pwm u_pwm (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_prescale_select(i_prescale_select),
    .i_duty(duty_q),
    .o_timer_tick(o_timer_tick),
    .o_wave(wave)
  );

  // ---------------------------------------------------------------
  // divider toggle
  // ---------------------------------------------------------------
  // cleared while stopped, so a stopped timer shows low on the pad
  always_ff @(posedge i_mclk) begin
    if (i_srst || !i_timer_on) begin
      pfd_q <= 1'b0;
    end else if (i_timer_ovf) begin
      pfd_q <= ~pfd_q;
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  always_comb begin
    o_port_a = pa_if.latch_q;
    if (PFD_OPTION) begin
      // latch bit is the enable set and cleared by software
      o_port_a[PA_LINE_DIVIDER] = pa_if.latch_q[PA_LINE_DIVIDER] & pfd_q;
    end
  end
  assign o_port_a_oe = ~pa_if.dir_q;
  assign o_port_b = pb_if.latch_q[4:0];
  assign o_port_b_oe = ~pb_if.dir_q[4:0];
  assign o_port_d = PWM_OPTION ? (pd_if.latch_q[PD_LINE_PWM] & wave)
    : pd_if.latch_q[PD_LINE_PWM];
  assign o_port_d_oe = ~pd_if.dir_q[PD_LINE_PWM];
  assign o_port_a_pullup = PULLUP_A;
  assign o_port_b_pullup = PULLUP_B;
  assign o_port_d_pullup = PULLUP_D;

  // shared input functions keep their normal path in input mode
  assign o_timer_clk_pin = i_port_a[PA_LINE_TIMER_CLK];
  assign o_ext_int_n = i_port_a[PA_LINE_EXT_INT];

  // ---------------------------------------------------------------
  // wake-up on any port a input change
  // ---------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      pa_prev_q <= 8'hff;
      wake_q <= 1'b0;
    end else begin
      pa_prev_q <= i_port_a;
      wake_q <= |((pa_prev_q ^ i_port_a) & pa_if.dir_q);
    end
  end
  assign o_wake = wake_q;
endmodule
`default_nettype wire

// ===== gio_chk.sv
// checker: port-level assertions for the i/o ports block
`timescale 1ns/1ns
`default_nettype none
module gio_chk (
  // clock, reset and bus
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic [7:0] i_addr,
  input wire logic i_wr,
  input wire logic [7:0] i_wdata,
  input wire logic i_rd,
  input wire logic i_bop,
  input wire logic o_rvalid,
  // timer and pins
  input wire logic [2:0] i_prescale_select,
  input wire logic i_timer_on,
  input wire logic i_timer_ovf,
  input wire logic o_timer_tick,
  input wire logic o_timer_clk_pin,
  input wire logic o_ext_int_n,
  input wire logic [7:0] i_port_a,
  input wire logic [7:0] o_port_a,
  input wire logic [7:0] o_port_a_oe,
  input wire logic [4:0] o_port_b_oe,
  input wire logic o_port_d_oe
);
  // ----------------
  // assertions
  // ----------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  a_read_answer: assert property (i_rd |=> o_rvalid)
    else $error("read got no answer");
  a_answer_cause: assert property (o_rvalid |-> $past(i_rd) || $past(i_bop))
    else $error("answer without request");
  a_dir_to_oe: assert property (i_wr && i_addr == 8'h13 |=> o_port_a_oe == ~$past(i_wdata))
    else $error("port a enables differ from direction");
  a_latch_write: assert property (i_wr && i_addr == 8'h12
    |=> (o_port_a | 8'h08) == ($past(i_wdata) | 8'h08))
    else $error("port a latch not written");
  a_latch_holds: assert property (!((i_wr || i_bop) && i_addr == 8'h12)
    |=> (o_port_a | 8'h08) == ($past(o_port_a) | 8'h08))
    else $error("port a latch changed unasked");
  a_reset_undriven: assert property ($past(i_srst)
    |-> o_port_a_oe == 8'h00 && o_port_b_oe == 5'h00 && !o_port_d_oe)
    else $error("line driven after reset");
  a_alt_inputs: assert property (o_timer_clk_pin == i_port_a[4]
    && o_ext_int_n == i_port_a[5])
    else $error("shared input not routed");
  a_div_stopped: assert property (!i_timer_on |=> !o_port_a[3])
    else $error("divider pin high with timer stopped");
  a_div_toggle: assert property (i_timer_on && i_timer_ovf && o_port_a[3] && !i_wr && !i_bop
    |=> !o_port_a[3])
    else $error("divider missed an overflow");
  a_div_steady: assert property (i_timer_on && !i_timer_ovf && !i_wr && !i_bop
    |=> $stable(o_port_a[3]))
    else $error("divider moved without overflow");
  a_tick_full: assert property (i_prescale_select == 3'h0 |-> o_timer_tick)
    else $error("undivided tick missing");
  // cover the main scenarios
  c_bop_answer: cover property (i_bop ##1 o_rvalid);
  c_div_rise: cover property ($rose(o_port_a[3]));
  c_all_out: cover property (o_port_a_oe == 8'hff);
endmodule
bind gio_top gio_chk u_gio_chk (.i_mclk, .i_srst, .i_addr, .i_wr, .i_wdata, .i_rd, .i_bop,
  .o_rvalid, .i_prescale_select, .i_timer_on, .i_timer_ovf, .o_timer_tick, .o_timer_clk_pin,
  .o_ext_int_n, .i_port_a, .o_port_a, .o_port_a_oe, .o_port_b_oe, .o_port_d_oe);
`default_nettype wire

// ===== gio_pad_mdl.sv
// partner: board-side pad model with optional pull-high
`timescale 1ns/1ns
`default_nettype none
module gio_pad_mdl #(
  parameter int W = 8,
  parameter bit PULL = 1'b1
) (
  // pins
  input wire logic [W-1:0] i_drv,
  input wire logic [W-1:0] i_oe,
  input wire logic [W-1:0] i_ext,
  input wire logic [W-1:0] i_en,
  output logic [W-1:0] o_pad
);
  // released line without pull never holds its last value
  logic flip = 1'b0;
  always #37 flip = ~flip;
  always_comb begin
    for (int k = 0; k < W; k++) begin
      o_pad[k] = i_oe[k] ? i_drv[k] : i_en[k] ? i_ext[k] : (PULL ? 1'b1 : flip);
    end
  end
endmodule
`default_nettype wire

// ===== gio_tb_top.sv
// testbench: random and corner tests of the i/o ports block
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
module gio_tb_top;
  import gio_pkg::*;
  // ----------------
  // signals
  // ----------------
  logic i_mclk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_bop = 1'b0;
  logic i_timer_on = 1'b0, i_timer_ovf = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, ext = 8'h00, en = 8'h00;
  logic [2:0] i_bop_bit = 3'h0, i_prescale_select = 3'h0;
  gio_bop_e i_bop_code = GIO_BOP_SET;
  logic [7:0] i_port_a, o_port_a, o_port_a_oe, o_rdata;
  logic [4:0] i_port_b, o_port_b, o_port_b_oe;
  logic i_port_d, o_port_d, o_port_d_oe, o_rvalid, o_timer_tick, o_wake, o_port_a_pullup;
  logic tclk, eint, pub, pud;
  logic [7:0] oe_p [3];
  logic [7:0] drv_p [3];
  localparam logic [7:0] LA [3] = '{8'h12, 8'h14, 8'h18};
  localparam logic [7:0] MK [3] = '{8'hff, 8'h1f, 8'h01};
  localparam logic [7:0] ALT [3] = '{8'h08, 8'h00, 8'h01};
  int error_cnt = 0, checked = 0, cyc = 0;
  logic [15:0] seed = 16'h02a1;
  gio_top u_gio_top (.i_mclk, .i_srst, .i_addr, .i_wr, .i_wdata, .i_rd, .i_bop, .i_bop_code,
    .i_bop_bit, .o_rdata, .o_rvalid, .i_prescale_select, .i_timer_on, .i_timer_ovf,
    .o_timer_tick, .o_timer_clk_pin(tclk), .o_ext_int_n(eint), .o_wake, .i_port_a, .o_port_a,
    .o_port_a_oe, .o_port_a_pullup, .i_port_b, .o_port_b, .o_port_b_oe, .o_port_b_pullup(pub),
    .i_port_d, .o_port_d, .o_port_d_oe, .o_port_d_pullup(pud));
  gio_pad_mdl #(.W(8)) u_pad_a (.i_drv(o_port_a), .i_oe(o_port_a_oe), .i_ext(ext),
    .i_en(en), .o_pad(i_port_a));
  gio_pad_mdl #(.W(5)) u_pad_b (.i_drv(o_port_b), .i_oe(o_port_b_oe), .i_ext(ext[4:0]),
    .i_en(en[4:0]), .o_pad(i_port_b));
  gio_pad_mdl #(.W(1)) u_pad_d (.i_drv(o_port_d), .i_oe(o_port_d_oe), .i_ext(ext[0]),
    .i_en(en[0]), .o_pad(i_port_d));
  always_comb begin
    oe_p = '{o_port_a_oe, {3'h0, o_port_b_oe}, {7'h00, o_port_d_oe}};
    drv_p = '{o_port_a, {3'h0, o_port_b}, {7'h00, o_port_d}};
  end
  initial forever #50 i_mclk = ~i_mclk;
  // ceiling well above the roughly 6000 cycles the tests need
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  // ----------------
  // helpers
  // ----------------
  function automatic logic [7:0] rnd();
    seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
    return seed[7:0];
  endfunction
  // input lines show the pad (floating ones pulled high), output lines the latch
  function automatic logic [7:0] exp_rd(input logic [7:0] d, l, m);
    return ((d & (ext | ~en)) | (~d & l)) & m;
  endfunction
  task automatic acc(input logic [7:0] a, d, input int k);
    @(negedge i_mclk);
    i_addr = a;
    i_wdata = d;
    if (k == 0) i_wr = 1'b1;
    else if (k == 1) i_rd = 1'b1;
    else i_bop = 1'b1;
    @(negedge i_mclk);
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_bop = 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, d);
    acc(a, d, 0);
  endtask
  task automatic rd(input logic [7:0] a, e);
    acc(a, 8'h00, 1);
    `CHK("rvalid", 1'b1, o_rvalid)
    `CHK("rdata", e, o_rdata)
  endtask
  task automatic cnt_hi(input int n, s, output int c);
    c = 0;
    repeat (n) begin
      @(negedge i_mclk);
      c += (s == 0) ? o_port_d : (s == 1) ? o_timer_tick : o_wake;
    end
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    logic [7:0] d, l, r, n, b;
    int p, c, t, k;
    repeat (16) @(negedge i_mclk);
    i_srst = 1'b0;
    `CHK("oe", 8'h00, o_port_a_oe)
    `CHK("pullup", 1'b1, o_port_a_pullup)
    `CHK("pullup b", 1'b1, pub)
    `CHK("pullup d", 1'b1, pud)
    for (p = 0; p < 3; p++) rd(LA[p] + 8'h01, MK[p]);
    rd(8'h1a, 8'h00);
    wr(8'h16, 8'h5a);
    rd(8'h16, 8'h00);
    for (k = 0; k < 60; k++) begin
      p = k % 3;
      d = rnd();
      l = rnd();
      en = rnd();
      wr(LA[p], l);
      wr(LA[p] + 8'h01, d);
      ext = rnd();
      rd(LA[p], exp_rd(d, l, MK[p]));
      rd(LA[p] + 8'h01, d & MK[p]);
      `CHK("oe", ~d & MK[p], oe_p[p])
      `CHK("drive", l & ~d & MK[p] & ~ALT[p], drv_p[p] & ~d & ~ALT[p])
    end
    wr(8'h13, 8'hf0);
    en = 8'hff;
    for (k = 0; k < 4; k++) begin
      l = rnd();
      d = rnd();
      ext = rnd();
      i_bop_bit = d[2:0];
      wr(8'h12, l);
      r = exp_rd(8'hf0, l, 8'hff);
      i_bop_code = gio_bop_e'(k);
      acc(8'h12, 8'h00, 2);
      b = 8'h01 << i_bop_bit;
      n = (k == 0) ? r | b : (k == 1) ? r & ~b : (k == 2) ? ~r : l;
      if (k == 3) `CHK("cpla", ~r, o_rdata)
      wr(8'h13, 8'h00);
      rd(8'h12, n);
      wr(8'h13, 8'hf0);
    end
    wr(8'h19, 8'h00);
    wr(8'h18, 8'h01);
    for (k = 0; k < 6; k++) begin
      d = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : (k == 2) ? 8'h05 : rnd();
      wr(8'h1a, d);
      rd(8'h1a, d);
      repeat (260) @(negedge i_mclk);
      t = 0;
      for (p = 0; p < 4; p++) begin
        cnt_hi(64, 0, c);
        t += c;
        `CHK("mod cycle", 1'b1, c == d[7:2] || c == d[7:2] + 1)
      end
      `CHK("period", 32'(d), t)
    end
    wr(8'h18, 8'h00);
    cnt_hi(256, 0, c);
    `CHK("forced low", 0, c)
    wr(8'h13, 8'h00);
    wr(8'h12, 8'hff);
    i_timer_on = 1'b1;
    for (k = 0; k < 5; k++) begin
      @(negedge i_mclk);
      i_timer_ovf = 1'b1;
      @(negedge i_mclk);
      i_timer_ovf = 1'b0;
      `CHK("divider", ~k[0], o_port_a[3])
    end
    i_bop_bit = 3'h3;
    i_bop_code = GIO_BOP_CLR;
    acc(8'h12, 8'h00, 2);
    `CHK("gate", 1'b0, o_port_a[3])
    i_bop_code = GIO_BOP_SET;
    acc(8'h12, 8'h00, 2);
    `CHK("gate", 1'b1, o_port_a[3])
    i_timer_on = 1'b0;
    @(negedge i_mclk);
    `CHK("stopped", 1'b0, o_port_a[3])
    for (k = 0; k < 8; k++) begin
      i_prescale_select = k[2:0];
      cnt_hi(256, 1, c);
      `CHK("ticks", 256 >> k, c)
    end
    wr(8'h13, 8'hff);
    ext = 8'h00;
    repeat (4) @(negedge i_mclk);
    `CHK("timer pin", 1'b0, tclk)
    `CHK("int pin", 1'b0, eint)
    ext = 8'h04;
    cnt_hi(4, 2, c);
    `CHK("wake", 1, c)
    ext = 8'h30;
    @(negedge i_mclk);
    `CHK("timer pin", 1'b1, tclk)
    `CHK("int pin", 1'b1, eint)
    complete_run();
  end
endmodule
`default_nettype wire
